//--- hdl/prtr_defines.vh
// register map, reset values and pin-class positions of the port pin control block
`ifndef PRTR_DEFINES_VH
`define PRTR_DEFINES_VH

// ----------------------------------------------------------------------------
// register offsets (byte addresses on the register port)
// ----------------------------------------------------------------------------
`define PRTR_OFS_DATA 16'h0280
`define PRTR_OFS_INPUT 16'h0281
`define PRTR_OFS_DIR 16'h0282
`define PRTR_OFS_DRIVE 16'h0283
`define PRTR_OFS_PULL_EN 16'h0284
`define PRTR_OFS_PULL_POL 16'h0285
`define PRTR_OFS_EDGE_FLAG 16'h0286

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PRTR_RST_DATA 8'h00
`define PRTR_RST_DIR 8'h00
`define PRTR_RST_DRIVE 8'h00
`define PRTR_RST_PULL_EN 8'hFF
`define PRTR_RST_PULL_POL 8'h00
`define PRTR_RST_EDGE_FLAG 4'h0
`define PRTR_RST_RDATA 8'h00

// ----------------------------------------------------------------------------
// pin classes and timing
// ----------------------------------------------------------------------------
`define PRTR_SEG_LO 4
`define PRTR_SCL_PIN 6
`define PRTR_SDA_PIN 5
`define PRTR_EDGE_PINS 4
`define PRTR_SYNC_STAGES 2

`endif

//--- hdl/prtr_sync.v
// two-flop level synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module prtr_sync #(
    parameter W = 8
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);

    // first stage feeds only the second stage
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // prtr_sync

`default_nettype wire

//--- hdl/prtr_edge.v
// polarity-selectable edge detector with sticky, write-one-to-clear flags
`timescale 1ns/1ps
`default_nettype none

module prtr_edge #(
    parameter W = 4
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire [W-1:0] sample_i,
    input wire [W-1:0] rising_sel_i,
    input wire [W-1:0] clear_i,
    output wire [W-1:0] flag_o
);

    reg [W-1:0] prev_q;
    reg [W-1:0] flag_q;
    wire [W-1:0] rise;
    wire [W-1:0] fall;
    wire [W-1:0] hit;
    wire [W-1:0] flag_d;

    assign rise = sample_i & ~prev_q;
    assign fall = ~sample_i & prev_q;
    // polarity 1 picks the rising edge, 0 the falling edge
    assign hit = (rising_sel_i & rise) | (~rising_sel_i & fall);
    // an edge in the clearing cycle keeps the flag set
    assign flag_d = (flag_q & ~clear_i) | hit;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_q <= {W{1'b0}};
            flag_q <= {W{1'b0}};
        end else begin
            prev_q <= sample_i;
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;

endmodule // prtr_edge

`default_nettype wire

//--- hdl/prtr_port.v
// pin control for one 8-bit general-purpose port with alternate-function overrides
`timescale 1ns/1ps
`default_nettype none
`include "prtr_defines.vh"

module prtr_port #(
    parameter N = 8
) (
    input wire clk_i,
    input wire rst_n_i,
    // register port
    input wire [15:0] addr_i,
    input wire [N-1:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output wire [N-1:0] rdata_o,
    // alternate-function owners
    input wire [N-`PRTR_SEG_LO-1:0] seg_en_i,
    input wire two_wire_route_i,
    input wire two_wire_en_i,
    input wire scl_drive_i,
    input wire sda_drive_i,
    input wire timer_route_i,
    input wire [`PRTR_EDGE_PINS-1:0] timer_oc_en_i,
    input wire [`PRTR_EDGE_PINS-1:0] timer_oc_val_i,
    // pad side
    input wire [N-1:0] pin_i,
    output wire [N-1:0] pin_o,
    output wire [N-1:0] pin_oe_n_o,
    output wire [N-1:0] in_buf_en_o,
    output wire [N-1:0] reduced_drive_o,
    output wire [N-1:0] pull_on_o,
    output wire [N-1:0] pull_down_o,
    // synchronised view for the alternate functions
    output wire [N-1:0] pin_view_o,
    output wire [`PRTR_EDGE_PINS-1:0] edge_flag_o
);

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    // full 16-bit compare, so no register answers at an alias
    function hit;
        input [15:0] a;
        input [15:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    wire wr_data;
    wire wr_dir;
    wire wr_drive;
    wire wr_pull_en;
    wire wr_pull_pol;
    wire wr_flag;

    assign wr_data = wr_i && hit(addr_i, `PRTR_OFS_DATA);
    assign wr_dir = wr_i && hit(addr_i, `PRTR_OFS_DIR);
    assign wr_drive = wr_i && hit(addr_i, `PRTR_OFS_DRIVE);
    assign wr_pull_en = wr_i && hit(addr_i, `PRTR_OFS_PULL_EN);
    assign wr_pull_pol = wr_i && hit(addr_i, `PRTR_OFS_PULL_POL);
    assign wr_flag = wr_i && hit(addr_i, `PRTR_OFS_EDGE_FLAG);
    // the input view offset has no write decode at all, so writes there
    // fall through without touching any state

    // ------------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------------
    reg [N-1:0] port_data_bits_q;
    reg [N-1:0] direction_bits_q;
    reg [N-1:0] drive_strength_bits_q;
    reg [N-1:0] pull_enable_bits_q;
    reg [N-1:0] pull_polarity_bits_q;
    reg [N-1:0] port_data_bits_d;
    reg [N-1:0] direction_bits_d;
    reg [N-1:0] drive_strength_bits_d;
    reg [N-1:0] pull_enable_bits_d;
    reg [N-1:0] pull_polarity_bits_d;

    // each register holds unless its own offset is written
    always @* begin
        port_data_bits_d = port_data_bits_q;
        direction_bits_d = direction_bits_q;
        drive_strength_bits_d = drive_strength_bits_q;
        pull_enable_bits_d = pull_enable_bits_q;
        pull_polarity_bits_d = pull_polarity_bits_q;
        if (wr_data) begin
            port_data_bits_d = wdata_i;
        end
        if (wr_dir) begin
            direction_bits_d = wdata_i;
        end
        if (wr_drive) begin
            drive_strength_bits_d = wdata_i;
        end
        if (wr_pull_en) begin
            pull_enable_bits_d = wdata_i;
        end
        if (wr_pull_pol) begin
            pull_polarity_bits_d = wdata_i;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_data_bits_q <= `PRTR_RST_DATA;
            direction_bits_q <= `PRTR_RST_DIR;
            drive_strength_bits_q <= `PRTR_RST_DRIVE;
            pull_enable_bits_q <= `PRTR_RST_PULL_EN;
            pull_polarity_bits_q <= `PRTR_RST_PULL_POL;
        end else begin
            port_data_bits_q <= port_data_bits_d;
            direction_bits_q <= direction_bits_d;
            drive_strength_bits_q <= drive_strength_bits_d;
            pull_enable_bits_q <= pull_enable_bits_d;
            pull_polarity_bits_q <= pull_polarity_bits_d;
        end
    end

    // ------------------------------------------------------------------------
    // pin input synchronisation
    // ------------------------------------------------------------------------
    wire [N-1:0] pin_sync;
    wire [N-1:0] pin_input_view;

    prtr_sync #(
        .W(N)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(pin_i),
        .sync_o(pin_sync)
    );
    // the synchroniser resets low, so the first two cycles after reset
    // read every pin as low whatever its level

    // ------------------------------------------------------------------------
    // per-pin ownership and pad control
    // ------------------------------------------------------------------------
    // drives is the pad enable, is_output the pin's mode for pulls and drive
    wire [N-1:0] seg_own;
    wire [N-1:0] drives;
    wire [N-1:0] out_val;
    wire [N-1:0] is_output;

    genvar i;
    generate
        // pins 3-0 serve the timer channels, 7-4 the segment driver
        for (i = 0; i < N; i = i + 1) begin : g_pin
            if (i >= `PRTR_SEG_LO) begin : g_seg
                // segment driver beats every other owner of the pin
                assign seg_own[i] = seg_en_i[i-`PRTR_SEG_LO];
                if (i == `PRTR_SCL_PIN || i == `PRTR_SDA_PIN) begin : g_tw
                    wire tw_own;
                    wire tw_val;
                    assign tw_own = ~seg_own[i] & two_wire_route_i & two_wire_en_i;
                    assign tw_val = (i == `PRTR_SCL_PIN) ? scl_drive_i : sda_drive_i;
                    // open drain while two-wire owns the pin: only a low level is driven
                    assign is_output[i] = ~seg_own[i] & (tw_own | direction_bits_q[i]);
                    assign drives[i] = seg_own[i] ? 1'b0 :
                        tw_own ? ~tw_val : direction_bits_q[i];
                    assign out_val[i] = tw_own ? 1'b0 : port_data_bits_q[i];
                end else begin : g_plain
                    assign is_output[i] = ~seg_own[i] & direction_bits_q[i];
                    assign drives[i] = is_output[i];
                    assign out_val[i] = port_data_bits_q[i];
                end
            end else begin : g_tim
                wire tim_own;
                assign seg_own[i] = 1'b0;
                assign tim_own = timer_route_i & timer_oc_en_i[i];
                assign is_output[i] = tim_own | direction_bits_q[i];
                assign drives[i] = is_output[i];
                assign out_val[i] = tim_own ? timer_oc_val_i[i] :
                    port_data_bits_q[i];
            end
        end
    endgenerate

    // a disabled input buffer reads as low, the pad is floating then
    assign pin_input_view = pin_sync & ~seg_own;

    // ------------------------------------------------------------------------
    // registered pad controls
    // ------------------------------------------------------------------------
    // registering costs one cycle of latency but keeps the pad outputs glitch free
    reg [N-1:0] pin_q;
    reg [N-1:0] oe_n_q;
    reg [N-1:0] in_buf_q;
    reg [N-1:0] reduced_q;
    reg [N-1:0] pull_on_q;
    reg [N-1:0] pull_down_q;
    wire [N-1:0] is_input;
    wire [N-1:0] pin_d;
    wire [N-1:0] oe_n_d;
    wire [N-1:0] in_buf_d;
    wire [N-1:0] reduced_d;
    wire [N-1:0] pull_on_d;
    wire [N-1:0] pull_down_d;

    // a segment-owned pin is neither input nor output
    assign is_input = ~is_output & ~seg_own;
    assign pin_d = out_val;
    assign oe_n_d = ~drives;
    assign in_buf_d = ~seg_own;
    assign reduced_d = drive_strength_bits_q & is_output;
    assign pull_on_d = pull_enable_bits_q & is_input;
    assign pull_down_d = pull_on_d & pull_polarity_bits_q;
    // pull and drive follow one registered owner: a pin never pulls while driven

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_q <= {N{1'b0}};
            oe_n_q <= {N{1'b1}};
            in_buf_q <= {N{1'b1}};
            reduced_q <= {N{1'b0}};
            pull_on_q <= `PRTR_RST_PULL_EN;
            pull_down_q <= `PRTR_RST_PULL_EN & `PRTR_RST_PULL_POL;
        end else begin
            pin_q <= pin_d;
            oe_n_q <= oe_n_d;
            in_buf_q <= in_buf_d;
            reduced_q <= reduced_d;
            pull_on_q <= pull_on_d;
            pull_down_q <= pull_down_d;
        end
    end

    assign pin_o = pin_q;
    assign pin_oe_n_o = oe_n_q;
    assign in_buf_en_o = in_buf_q;
    assign reduced_drive_o = reduced_q;
    assign pull_on_o = pull_on_q;
    assign pull_down_o = pull_down_q;
    assign pin_view_o = pin_input_view;

    // ------------------------------------------------------------------------
    // edge detection on the low pins
    // ------------------------------------------------------------------------
    wire [`PRTR_EDGE_PINS-1:0] edge_flag_bits;
    wire [`PRTR_EDGE_PINS-1:0] flag_clear;

    // the detector runs on the masked view whatever the direction, so a
    // pin driven as an output still flags its own edges
    // write one to clear; a zero bit leaves its flag alone
    assign flag_clear = wr_flag ? wdata_i[`PRTR_EDGE_PINS-1:0] : `PRTR_RST_EDGE_FLAG;

    prtr_edge #(
        .W(`PRTR_EDGE_PINS)
    ) u_edge (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sample_i(pin_input_view[`PRTR_EDGE_PINS-1:0]),
        .rising_sel_i(pull_polarity_bits_q[`PRTR_EDGE_PINS-1:0]),
        .clear_i(flag_clear),
        .flag_o(edge_flag_bits)
    );

    assign edge_flag_o = edge_flag_bits;

    // ------------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------------
    reg [N-1:0] rdata_q;
    reg [N-1:0] rdata_d;
    wire [N-1:0] data_view;
    wire [N-1:0] flag_view;

    // the direction bit, not the effective owner, picks the source: a
    // timer or two-wire pin with its direction bit clear reads its pin level
    assign data_view = (direction_bits_q & port_data_bits_q) |
        (~direction_bits_q & pin_input_view);
    // unused upper flag bits read as zero
    assign flag_view = {{(N-`PRTR_EDGE_PINS){1'b0}}, edge_flag_bits};
    // reads have no side effects, so polling never loses a flag

    always @* begin
        rdata_d = `PRTR_RST_RDATA;
        if (rd_i) begin
            case (addr_i)
                `PRTR_OFS_DATA: begin
                    rdata_d = data_view;
                end
                `PRTR_OFS_INPUT: begin
                    rdata_d = pin_input_view;
                end
                `PRTR_OFS_DIR: begin
                    rdata_d = direction_bits_q;
                end
                `PRTR_OFS_DRIVE: begin
                    rdata_d = drive_strength_bits_q;
                end
                `PRTR_OFS_PULL_EN: begin
                    rdata_d = pull_enable_bits_q;
                end
                `PRTR_OFS_PULL_POL: begin
                    rdata_d = pull_polarity_bits_q;
                end
                `PRTR_OFS_EDGE_FLAG: begin
                    rdata_d = flag_view;
                end
                default: begin
                    rdata_d = `PRTR_RST_RDATA;
                end
            endcase
        end
    end

    // data stands only in the cycle after the read strobe
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= `PRTR_RST_RDATA;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

endmodule // prtr_port

`default_nettype wire

//--- dv/prtr_port_sva.sv
// assertion checker for the port pin control block
`timescale 1ns/1ps
`default_nettype none
module prtr_port_sva #(
    parameter N = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [N-1:0] rdata_o,
    input wire logic [N-5:0] seg_en_i,
    input wire logic two_wire_route_i,
    input wire logic two_wire_en_i,
    input wire logic scl_drive_i,
    input wire logic sda_drive_i,
    input wire logic timer_route_i,
    input wire logic [3:0] timer_oc_en_i,
    input wire logic [3:0] timer_oc_val_i,
    input wire logic [N-1:0] pin_o,
    input wire logic [N-1:0] pin_oe_n_o,
    input wire logic [N-1:0] in_buf_en_o,
    input wire logic [N-1:0] reduced_drive_o,
    input wire logic [N-1:0] pull_on_o,
    input wire logic [N-1:0] pull_down_o,
    input wire logic [N-1:0] pin_view_o,
    input wire logic [3:0] edge_flag_o
);
    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // segment on pins 6,5 outranks the two-wire owner
    sequence tw_owns;
        two_wire_route_i && two_wire_en_i && !seg_en_i[2] && !seg_en_i[1];
    endsequence
    sequence rise0;
        pull_on_o[0] && pull_down_o[0] && $rose(pin_view_o[0]);
    endsequence
    sequence fall1;
        pull_on_o[1] && !pull_down_o[1] && $fell(pin_view_o[1]);
    endsequence
    a_view_read: assert property (rd_i && addr_i == 16'h0281 |=> rdata_o == $past(pin_view_o))
        else $error("input view read differs from synchronised pins");
    a_seg_release: assert property (seg_en_i != 4'h0 |=>
        ((pin_oe_n_o[7:4] & $past(seg_en_i)) == $past(seg_en_i))
        && ((in_buf_en_o[7:4] & $past(seg_en_i)) == 4'h0))
        else $error("segment pin still has a buffer enabled");
    a_two_wire_od: assert property (tw_owns |=> pin_o[6:5] == 2'b00
        && pin_oe_n_o[6:5] == {$past(scl_drive_i), $past(sda_drive_i)})
        else $error("two-wire pins not open-drain");
    a_timer_force: assert property (timer_route_i |=>
        ((~pin_oe_n_o[3:0] | ~$past(timer_oc_en_i)) == 4'hF)
        && (((pin_o[3:0] ^ $past(timer_oc_val_i)) & $past(timer_oc_en_i)) == 4'h0))
        else $error("timer pin not forced to output");
    a_pull_inputs: assert property ((pull_on_o & ~pin_oe_n_o) == 8'h00)
        else $error("pull device on a driven pin");
    a_pull_down_on: assert property ((pull_down_o & ~pull_on_o) == 8'h00)
        else $error("pull-down without pull enable");
    a_reduced_input: assert property ((reduced_drive_o & pull_on_o) == 8'h00)
        else $error("reduced drive on an input pin");
    a_rise_flag: assert property (rise0 |=> edge_flag_o[0])
        else $error("rising edge did not set flag");
    a_fall_flag: assert property (fall1 |=> edge_flag_o[1])
        else $error("falling edge did not set flag");
    a_flag_sticky: assert property (!(wr_i && addr_i == 16'h0286) |=>
        (edge_flag_o & $past(edge_flag_o)) == $past(edge_flag_o))
        else $error("edge flag dropped without a clear");
endmodule // prtr_port_sva

bind prtr_port prtr_port_sva #(.N(N)) u_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .seg_en_i(seg_en_i), .two_wire_route_i(two_wire_route_i),
    .two_wire_en_i(two_wire_en_i), .scl_drive_i(scl_drive_i), .sda_drive_i(sda_drive_i),
    .timer_route_i(timer_route_i), .timer_oc_en_i(timer_oc_en_i),
    .timer_oc_val_i(timer_oc_val_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
    .in_buf_en_o(in_buf_en_o), .reduced_drive_o(reduced_drive_o), .pull_on_o(pull_on_o),
    .pull_down_o(pull_down_o), .pin_view_o(pin_view_o), .edge_flag_o(edge_flag_o)
);
`default_nettype wire

//--- dv/prtr_board.sv
// board model resolving each port pin from pad drive, pulls and test drivers
`timescale 1ns/1ps
`default_nettype none
module prtr_board (
    input wire logic clk_i,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_n_o,
    input wire logic [7:0] pull_on_o,
    input wire logic [7:0] pull_down_o,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    input wire logic [7:0] short_i,
    output logic [7:0] pin_i
);
    // a floating pin wanders, so no settled value can pass for a driven one
    logic float_q = 1'b0;
    always @(posedge clk_i) float_q <= ~float_q;
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            if (short_i[k]) pin_i[k] = ext_val_i[k];
            else if (!pin_oe_n_o[k]) pin_i[k] = pin_o[k];
            else if (ext_en_i[k]) pin_i[k] = ext_val_i[k];
            else if (pull_on_o[k]) pin_i[k] = ~pull_down_o[k];
            else pin_i[k] = float_q;
        end
    end
endmodule // prtr_board
`default_nettype wire

//--- dv/prtr_port_tb.sv
// self-checking testbench for the port pin control block
`timescale 1ns/1ps
`default_nettype none
`include "prtr_defines.vh"
module prtr_port_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [3:0] seg_en_i = 4'h0;
    logic tw_route = 1'b0;
    logic tw_en = 1'b0;
    logic scl_drv = 1'b1;
    logic sda_drv = 1'b1;
    logic tm_route = 1'b0;
    logic [3:0] oc_en = 4'h0;
    logic [3:0] oc_val = 4'h0;
    logic [7:0] ext_en = 8'hFF;
    logic [7:0] ext_val = 8'hA5;
    logic [7:0] short = 8'h00;
    wire [7:0] rdata_o, pin_o, oe_n, ibuf, red, pull_on, pull_dn, view, pin_i;
    wire [3:0] flag;
    integer mismatches = 0;
    integer compares = 0;

    prtr_port #(.N(8)) uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .seg_en_i(seg_en_i),
        .two_wire_route_i(tw_route), .two_wire_en_i(tw_en), .scl_drive_i(scl_drv),
        .sda_drive_i(sda_drv), .timer_route_i(tm_route), .timer_oc_en_i(oc_en),
        .timer_oc_val_i(oc_val), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(oe_n),
        .in_buf_en_o(ibuf), .reduced_drive_o(red), .pull_on_o(pull_on),
        .pull_down_o(pull_dn), .pin_view_o(view), .edge_flag_o(flag)
    );
    prtr_board u_board (
        .clk_i(clk_i), .pin_o(pin_o), .pin_oe_n_o(oe_n), .pull_on_o(pull_on),
        .pull_down_o(pull_dn), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .short_i(short), .pin_i(pin_i)
    );

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rc(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk(oe_n, 8'hFF);
        chk(pull_on, 8'hFF);
        rc(`PRTR_OFS_DIR, 8'h00);
        rc(`PRTR_OFS_PULL_EN, 8'hFF);
        rc(16'h0287, 8'h00);
    endtask
    task automatic t_input;
        rc(`PRTR_OFS_INPUT, 8'hA5);
        rc(`PRTR_OFS_DATA, 8'hA5);
        wr(`PRTR_OFS_INPUT, 8'hFF);
        rc(`PRTR_OFS_INPUT, 8'hA5);
        rc(`PRTR_OFS_DIR, 8'h00);
        chk(oe_n, 8'hFF);
        wr(`PRTR_OFS_DATA, 8'h3C);
        wr(`PRTR_OFS_DIR, 8'hFF);
        wt(4);
        chk(oe_n, 8'h00);
        chk(pin_o, 8'h3C);
        rc(`PRTR_OFS_INPUT, 8'h3C);
        @(posedge clk_i) short <= 8'h01;
        wt(3);
        rc(`PRTR_OFS_INPUT, 8'h3D);
        rc(`PRTR_OFS_DATA, 8'h3C);
        @(posedge clk_i) short <= 8'h00;
    endtask
    task automatic t_pull;
        wr(`PRTR_OFS_DIR, 8'h00);
        wr(`PRTR_OFS_PULL_EN, 8'h0F);
        wr(`PRTR_OFS_PULL_POL, 8'h05);
        wr(`PRTR_OFS_DRIVE, 8'hFF);
        wt(2);
        chk(pull_on, 8'h0F);
        chk(pull_dn, 8'h05);
        chk(red, 8'h00);
        rc(`PRTR_OFS_DRIVE, 8'hFF);
        rc(`PRTR_OFS_PULL_POL, 8'h05);
        wr(`PRTR_OFS_DIR, 8'h03);
        wt(2);
        chk(pull_on, 8'h0C);
        chk(pull_dn, 8'h04);
        chk(red, 8'h03);
        wr(`PRTR_OFS_DIR, 8'h00);
    endtask
    task automatic t_override;
        @(posedge clk_i) seg_en_i <= 4'hF;
        wt(2);
        chk({oe_n[7:4], ibuf[7:4]}, 8'hF0);
        chk(view & 8'hF0, 8'h00);
        @(posedge clk_i) begin
            seg_en_i <= 4'h0;
            {tw_route, tw_en, scl_drv, sda_drv} <= 4'hD;
            {tm_route, oc_en, oc_val} <= 9'h1FA;
        end
        wt(2);
        chk(oe_n, 8'hB0);
        chk(pin_o & 8'h6F, 8'h0A);
        @(posedge clk_i) seg_en_i <= 4'h6;
        wt(2);
        chk(oe_n, 8'hF0);
        @(posedge clk_i) begin
            {seg_en_i, tw_route, tm_route} <= 6'h00;
        end
        wt(2);
        chk(oe_n, 8'hFF);
    endtask
    task automatic t_edge;
        @(posedge clk_i) ext_val <= 8'h02;
        wr(`PRTR_OFS_PULL_POL, 8'h01);
        wt(4);
        wr(`PRTR_OFS_EDGE_FLAG, 8'h0F);
        rc(`PRTR_OFS_EDGE_FLAG, 8'h00);
        @(posedge clk_i) ext_val <= 8'h05;
        wt(5);
        rc(`PRTR_OFS_EDGE_FLAG, 8'h03);
        wr(`PRTR_OFS_EDGE_FLAG, 8'h01);
        rc(`PRTR_OFS_EDGE_FLAG, 8'h02);
        chk({4'h0, flag}, 8'h02);
    endtask

    task automatic results;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wt(3);
        t_reset;
        t_input;
        t_pull;
        t_override;
        t_edge;
        results;
    end
    // the run needs a little over a hundred cycles; far beyond that means a hang
    initial begin
        #80000;
        mismatches++;
        results;
    end
endmodule // prtr_port_tb
`default_nettype wire
